// [shared/fault_sgi_cfg.svh]
// Purpose: offsets, field positions, reset values for the fault address / soft interrupt block
// Assumes: byte addresses on a 32-bit classic Wishbone slave
// Notes: definitions only
`ifndef FAULT_SGI_CFG_SVH
`define FAULT_SGI_CFG_SVH
`define FSGI_ADDR_W 12
`define FSGI_OFF_FAULT_ADDR 12'hd38
`define FSGI_OFF_SOFT_TRIG 12'hf00
`define FSGI_OFF_FAULT_STATUS 12'hd28
`define FSGI_OFF_CONFIG_CTRL 12'hd14
`define FSGI_OFF_IRQ_STATUS 12'hd00
`define FSGI_OFF_IRQ_MASK 12'hd04
`define FSGI_OFF_SGI_PEND 12'hd08
`define FSGI_SGI_PEND_WORDS 8
`define FSGI_FAULT_ADDR_RST 32'h0000_0000
`define FSGI_INTERRUPT_IDENTIFIER_MSB 7
`define FSGI_INTERRUPT_IDENTIFIER_LSB 0
`define FSGI_VALID_BIT 7
`define FSGI_PRECISE_BIT 1
`define FSGI_IMPRECISE_BIT 2
`define FSGI_UNPRIV_EN_BIT 1
`define FSGI_EV_FAULT_BIT 0
`define FSGI_EV_SGI_BIT 1
`define FSGI_EV_DENY_BIT 2
`define FSGI_EV_W 3
`endif

// [shared/fault_sgi_pkg.sv]
// Purpose: types shared by the fault address / soft interrupt block
// Assumes: the cfg header supplies every number
// Notes: structs carry the bus request and the fault report
`include "fault_sgi_cfg.svh"
package fault_sgi_pkg;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [`FSGI_ADDR_W-1:0] adr;
      logic [31:0] dat;
      logic priv;
   } wb_req_t;
   typedef struct packed {
      logic valid;
      logic precise;
      logic [31:0] reqAddr;
   } fault_rpt_t;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK = 2'b01,
      BUS_ERR = 2'b10
   } bus_state_t;
endpackage

// [src/sgi_pend_mem.sv]
// Purpose: pending bits for 256 software-generated interrupt lines
// Assumes: one set and one clear per cycle
// Notes: read word comes out of a register
`timescale 1ns/1ns
module sgi_pend_mem (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic setEn,
   input wire logic [7:0] setId,
   input wire logic clrEn,
   input wire logic [7:0] clrId,
   input wire logic [2:0] rdWord,
   output logic [31:0] rdData_r,
   output logic [255:0] pend_r
);
   logic [255:0] pend_nxt;
   // set wins over clear for the same line
   always_comb begin
      pend_nxt = pend_r;
      if (clrEn) begin
         pend_nxt[clrId] = 1'b0;
      end
      if (setEn) begin
         pend_nxt[setId] = 1'b1;
      end
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pend_r <= 256'h0;
         rdData_r <= 32'h0;
      end else begin
         pend_r <= pend_nxt;
         rdData_r <= pend_r[rdWord*32 +: 32];
      end
   end
endmodule

// [src/fault_status_bits.sv]
// Purpose: bus fault status flags, write one to clear
// Assumes: fault reports are one-cycle pulses from the core
// Notes: a new fault in the clearing cycle survives
`timescale 1ns/1ns
`include "fault_sgi_cfg.svh"
module fault_status_bits (
   input wire logic core_clk,
   input wire logic srst,
   input wire fault_sgi_pkg::fault_rpt_t rpt,
   input wire logic clrWr,
   input wire logic [31:0] clrData,
   output logic [7:0] stat_r
);
   logic [7:0] stat_nxt;
   logic [7:0] setMask;
   // set terms per event kind
   assign setMask = rpt.valid ? ((8'h1 << `FSGI_VALID_BIT)
      | (rpt.precise ? (8'h1 << `FSGI_PRECISE_BIT) : (8'h1 << `FSGI_IMPRECISE_BIT))) : 8'h0;
   assign stat_nxt = (stat_r & ~(clrWr ? clrData[7:0] : 8'h0)) | setMask;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         stat_r <= 8'h0;
      end else begin
         stat_r <= stat_nxt;
      end
   end
endmodule

// [src/fault_address_and_soft_irq.sv]
// Purpose: bus fault address capture and software interrupt trigger behind Wishbone
// Assumes: priv qualifies each request; faults reported as one-cycle pulses
// Notes: ack or err one cycle after the request is seen
`timescale 1ns/1ns
`include "fault_sgi_cfg.svh"
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - a bus fault stores its 32-bit address in the fault address register
// - unaligned faults store the address the instruction asked for
// - stored address valid only while the status valid flag is set
// - fault address register privileged only, read/write, resets to zero
// - writing an interrupt number to the trigger register pends that interrupt
// - low 8 bits write-only identifier; upper bits read zero
// - unprivileged trigger writes accepted when the enable bit is set
// - only privileged software may change the unprivileged enable bit
// - fault status bits clear only on writing one
module fault_address_and_soft_irq (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [`FSGI_ADDR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic privAccess,
   input wire logic faultPulse,
   input wire logic faultPrecise,
   input wire logic [31:0] faultReqAddr,
   input wire logic sgiAckEn,
   input wire logic [7:0] sgiAckId,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   output logic sgiStrobe_r,
   output logic [7:0] sgiId_r,
   output logic irq_r
);
   //////////////////////////////////////////////////////////////////////////////
   localparam logic [`FSGI_ADDR_W-1:0] PEND_BASE = `FSGI_OFF_SGI_PEND;
   fault_sgi_pkg::wb_req_t req;
   fault_sgi_pkg::fault_rpt_t rpt;
   fault_sgi_pkg::bus_state_t busState_r, busState_nxt;
   logic [31:0] bus_fault_address_r, bus_fault_address_nxt;
   logic unprivEn_r;
   logic [`FSGI_EV_W-1:0] evStat_r, evStat_nxt, evMask_r, evSet;
   logic [7:0] faultStat;
   logic [31:0] pendWord;
   logic [255:0] pendAll;
   logic [31:0] rdMux, dat_r;
   logic ack_r, err_r;
   logic newReq, isFault, isTrig, isStat, isCfg, isEvs, isEvm, isPend, mapped;
   logic allowed, wrOk, rdOk, sgiFire, pendAny;
   logic [31:0] wMask;

   // byte lanes turned into a bit mask
   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   // address match against an aligned word
   function automatic logic hit(input logic [`FSGI_ADDR_W-1:0] a, input logic [`FSGI_ADDR_W-1:0] off);
      hit = (a[`FSGI_ADDR_W-1:2] == off[`FSGI_ADDR_W-1:2]);
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   // request carried as one struct
   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                  adr: wb_adr_i, dat: wb_dat_i, priv: privAccess};
   assign rpt = '{valid: faultPulse, precise: faultPrecise, reqAddr: faultReqAddr};

   // one answer per request; the ack cycle itself takes no new request
   assign newReq = req.cyc & req.stb & (busState_r == fault_sgi_pkg::BUS_IDLE);
   assign isFault = hit(req.adr, `FSGI_OFF_FAULT_ADDR);
   assign isTrig = hit(req.adr, `FSGI_OFF_SOFT_TRIG);
   assign isStat = hit(req.adr, `FSGI_OFF_FAULT_STATUS);
   assign isCfg = hit(req.adr, `FSGI_OFF_CONFIG_CTRL);
   assign isEvs = hit(req.adr, `FSGI_OFF_IRQ_STATUS);
   assign isEvm = hit(req.adr, `FSGI_OFF_IRQ_MASK);
   // pend words fill only the holes of the window; real registers there must win the read path
   assign isPend = (req.adr[`FSGI_ADDR_W-1:5] == PEND_BASE[`FSGI_ADDR_W-1:5]) & ~isEvs & ~isEvm & ~isCfg;
   assign mapped = isFault | isTrig | isStat | isCfg | isEvs | isEvm | isPend;

   // privilege gate: only the trigger opens to user code, and only if enabled
   assign allowed = req.priv | (isTrig & unprivEn_r);
   assign wrOk = newReq & req.we & mapped & allowed;
   assign rdOk = newReq & ~req.we & mapped & allowed;
   assign wMask = lane_mask(req.sel);

   //////////////////////////////////////////////////////////////////////////////
   // bus state: unmapped or forbidden requests get err
   always_comb begin
      busState_nxt = fault_sgi_pkg::BUS_IDLE;
      case (busState_r)
         fault_sgi_pkg::BUS_IDLE: begin
            if (newReq) begin
               busState_nxt = (mapped & allowed) ? fault_sgi_pkg::BUS_ACK : fault_sgi_pkg::BUS_ERR;
            end
         end
         fault_sgi_pkg::BUS_ACK: busState_nxt = fault_sgi_pkg::BUS_IDLE;
         fault_sgi_pkg::BUS_ERR: busState_nxt = fault_sgi_pkg::BUS_IDLE;
         default: busState_nxt = fault_sgi_pkg::BUS_IDLE;
      endcase
   end

   //////////////////////////////////////////////////////////////////////////////
   // fault address: hardware capture beats a software write in the same cycle
   always_comb begin
      bus_fault_address_nxt = bus_fault_address_r;
      if (wrOk & isFault) begin
         bus_fault_address_nxt = (bus_fault_address_r & ~wMask) | (req.dat & wMask);
      end
      if (rpt.valid) begin
         bus_fault_address_nxt = rpt.reqAddr;
      end
   end

   // trigger fires on a byte-lane-0 write; id field is write-only
   assign sgiFire = wrOk & isTrig & req.sel[0];

   // event status: set beats write-one clear
   assign evSet = {newReq & ~(mapped & allowed), sgiFire, rpt.valid};
   assign evStat_nxt = (evStat_r & ~((wrOk & isEvs) ? req.dat[`FSGI_EV_W-1:0] : '0)) | evSet;
   assign pendAny = |pendAll;

   // read data select; trigger reads zero across all bits
   assign rdMux = isFault ? bus_fault_address_r :
                  isStat ? {24'h0, faultStat} :
                  isCfg ? {30'h0, unprivEn_r, 1'b0} :
                  isEvs ? {29'h0, evStat_r} :
                  isEvm ? {29'h0, evMask_r} :
                  isPend ? pendWord :
                  32'h0;

   //////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk) begin
      if (srst) begin
         busState_r <= fault_sgi_pkg::BUS_IDLE;
         bus_fault_address_r <= `FSGI_FAULT_ADDR_RST;
         unprivEn_r <= 1'b0;
         evStat_r <= '0;
         evMask_r <= '0;
      end else begin
         busState_r <= busState_nxt;
         bus_fault_address_r <= bus_fault_address_nxt;
         evStat_r <= evStat_nxt;
         if (wrOk & isCfg & req.sel[0]) begin
            unprivEn_r <= req.dat[`FSGI_UNPRIV_EN_BIT];
         end
         if (wrOk & isEvm & req.sel[0]) begin
            evMask_r <= req.dat[`FSGI_EV_W-1:0];
         end
      end
   end

   // outputs straight from flops, except wb_dat_o, muxed with the pend word by address
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ack_r <= 1'b0;
         err_r <= 1'b0;
         dat_r <= 32'h0;
         sgiStrobe_r <= 1'b0;
         sgiId_r <= 8'h0;
         irq_r <= 1'b0;
      end else begin
         ack_r <= newReq & mapped & allowed;
         err_r <= newReq & ~(mapped & allowed);
         dat_r <= rdOk ? rdMux : 32'h0;
         sgiStrobe_r <= sgiFire;
         if (sgiFire) begin
            sgiId_r <= req.dat[`FSGI_INTERRUPT_IDENTIFIER_MSB:`FSGI_INTERRUPT_IDENTIFIER_LSB];
         end
         irq_r <= |(evStat_nxt & evMask_r);
      end
   end

   // pend word read: the memory's own register stands in for dat_r, so no extra cycle
   assign wb_dat_o = (isPend & busState_r == fault_sgi_pkg::BUS_ACK) ? pendWord : dat_r;
   assign wb_ack_o = ack_r;
   assign wb_err_o = err_r;

   //////////////////////////////////////////////////////////////////////////////
   sgi_pend_mem u_pend (
      .core_clk(core_clk),
      .srst(srst),
      .setEn(sgiFire),
      .setId(req.dat[7:0]),
      .clrEn(sgiAckEn),
      .clrId(sgiAckId),
      .rdWord(req.adr[4:2]),
      .rdData_r(pendWord),
      .pend_r(pendAll)
   );

   fault_status_bits u_stat (
      .core_clk(core_clk),
      .srst(srst),
      .rpt(rpt),
      .clrWr(wrOk & isStat),
      .clrData(req.dat & wMask),
      .stat_r(faultStat)
   );
endmodule

// [tb/fault_address_and_soft_irq_checker.sv]
// Purpose: port assertions for the fault address / soft interrupt block
// Assumes: one clock, srst synchronous, answer one cycle after a request is taken
// Notes: bound to the top module at the foot of this file
`timescale 1ns/1ns
`include "fault_sgi_cfg.svh"
module fault_address_and_soft_irq_checker (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [`FSGI_ADDR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic privAccess,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic sgiStrobe_r,
   input wire logic [7:0] sgiId_r
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   // a request counts as taken only outside the answer cycle
   wire taken = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   wire trig = taken && wb_adr_i == `FSGI_OFF_SOFT_TRIG;
   a_single_answer: assert property (taken |=> wb_ack_o ^ wb_err_o)
      else $error("request not answered by exactly one of ack and err");
   a_fault_addr_priv: assert property (taken && !privAccess && wb_adr_i == `FSGI_OFF_FAULT_ADDR |=> wb_err_o)
      else $error("unprivileged fault address access not refused");
   a_cfg_priv_only: assert property (taken && !privAccess && wb_we_i && wb_adr_i == `FSGI_OFF_CONFIG_CTRL |=> wb_err_o)
      else $error("unprivileged config write not refused");
   a_trig_id_out: assert property (trig && privAccess && wb_we_i && wb_sel_i[0]
      |=> sgiStrobe_r && sgiId_r == $past(wb_dat_i[7:0]))
      else $error("trigger write did not raise its interrupt id");
   a_trig_reads_zero: assert property (trig && privAccess && !wb_we_i |=> wb_ack_o && wb_dat_o == 32'h0)
      else $error("trigger register read not zero");
   a_strobe_cause: assert property (sgiStrobe_r |-> $past(trig && wb_we_i))
      else $error("strobe without a trigger write");
   a_strobe_not_err: assert property (sgiStrobe_r |-> !wb_err_o)
      else $error("refused write still triggered");
   a_id_holds: assert property (!sgiStrobe_r |-> $stable(sgiId_r))
      else $error("interrupt id changed without a trigger");
endmodule
bind fault_address_and_soft_irq fault_address_and_soft_irq_checker i_fault_address_and_soft_irq_checker (
   .core_clk(core_clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .privAccess(privAccess),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .sgiStrobe_r(sgiStrobe_r),
   .sgiId_r(sgiId_r));

// [tb/core_side_model.sv]
// Purpose: core side that services pended software interrupts
// Assumes: one strobe per accepted trigger write
// Notes: services each line one cycle after its strobe, so pend bits do not pile up
`timescale 1ns/1ns
module core_side_model (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic sgiStrobe_r,
   input wire logic [7:0] sgiId_r,
   output logic sgiAckEn,
   output logic [7:0] sgiAckId
);
   // take the pended line as soon as it is raised
   always_ff @(posedge core_clk) begin
      sgiAckEn <= !srst && sgiStrobe_r;
      sgiAckId <= sgiId_r;
   end
endmodule

// [tb/fault_address_and_soft_irq_tb_top.sv]
// Purpose: self-checking bench for the fault address / soft interrupt block
// Assumes: classic Wishbone master, answer sampled at the rising edge
// Notes: expected values come from offsets and field positions only
`timescale 1ns/1ns
`include "fault_sgi_cfg.svh"
module fault_address_and_soft_irq_tb_top;
   localparam logic P = 1'b1;
   localparam logic U = 1'b0;
   localparam logic [11:0] FA = `FSGI_OFF_FAULT_ADDR;
   localparam logic [11:0] FS = `FSGI_OFF_FAULT_STATUS;
   localparam logic [11:0] TR = `FSGI_OFF_SOFT_TRIG;
   localparam logic [11:0] CF = `FSGI_OFF_CONFIG_CTRL;
   logic core_clk = 1'b0, srst = 1'b1, ack, err, stbOut, irq, ackEn, gotErr, gotStb;
   logic [7:0] sgiId, ackId;
   logic [31:0] dat, rd;
   fault_sgi_pkg::wb_req_t req = '0;
   fault_sgi_pkg::fault_rpt_t fr = '0;
   int n_errors = 0, checks_done = 0;
   fault_address_and_soft_irq i_fault_address_and_soft_irq (.core_clk(core_clk), .srst(srst),
      .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr),
      .wb_dat_i(req.dat), .privAccess(req.priv), .faultPulse(fr.valid), .faultPrecise(fr.precise),
      .faultReqAddr(fr.reqAddr), .sgiAckEn(ackEn), .sgiAckId(ackId), .wb_dat_o(dat), .wb_ack_o(ack),
      .wb_err_o(err), .sgiStrobe_r(stbOut), .sgiId_r(sgiId), .irq_r(irq));
   core_side_model i_core_side_model (.core_clk(core_clk), .srst(srst), .sgiStrobe_r(stbOut),
      .sgiId_r(sgiId), .sgiAckEn(ackEn), .sgiAckId(ackId));
   //////////////////////////////////////////////////////////////////////////////
   // shared tasks: verdict, compare, one bus cycle, one fault report
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // the request stands until ack or err is sampled; the answer is taken at that edge
   task automatic bus(input logic w, input logic p, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge core_clk);
      req <= '{1'b1, 1'b1, w, 4'hf, a, d, p};
      for (i = 0; i < 20; i++) begin
         @(posedge core_clk);
         if (ack === 1'b1 || err === 1'b1) break;
      end
      if (i == 20) begin
         n_errors++;
         end_of_test();
      end
      rd = dat;
      gotErr = err;
      gotStb = stbOut;
      req <= '0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic p, input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, p, a, d);
   endtask
   task automatic rdr(input logic p, input logic [11:0] a);
      bus(1'b0, p, a, 32'h0);
   endtask
   task automatic fault(input logic [31:0] a);
      @(posedge core_clk);
      fr <= '{1'b1, 1'b1, a};
      @(posedge core_clk);
      fr <= '0;
   endtask
   //////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_fault();
      rdr(P, FA);
      chk(rd, 32'h0);
      fault(32'h2000_0103); // unaligned request address
      rdr(P, FA);
      chk(rd, 32'h2000_0103);
      rdr(P, FS);
      chk(rd[`FSGI_VALID_BIT], 32'h1);
      wr(P, FS, 32'h0);
      rdr(P, FS);
      chk(rd[`FSGI_VALID_BIT], 32'h1);
      wr(P, FS, 32'h80);
      rdr(P, FS);
      chk(rd[`FSGI_VALID_BIT], 32'h0);
      wr(P, FA, 32'h55aa_0f0f);
      wr(U, FA, 32'h1234_5678);
      chk(gotErr, 32'h1);
      rdr(P, FA);
      chk(rd, 32'h55aa_0f0f);
   endtask
   task automatic t_trig();
      wr(P, TR, 32'hffff_ff03);
      chk(gotStb, 32'h1);
      chk(sgiId, 32'h3);
      rdr(P, TR);
      chk(rd, 32'h0);
      wr(U, TR, 32'h9);
      chk({gotErr, gotStb}, 32'h2);
      wr(U, CF, 32'h2);
      chk(gotErr, 32'h1);
      wr(P, CF, 32'h2);
      rdr(P, CF);
      chk(rd, 32'h2);
      wr(U, TR, 32'h5);
      chk({gotErr, gotStb}, 32'h1);
      chk(sgiId, 32'h5);
      rdr(P, 12'h100);
      chk(gotErr, 32'h1);
   endtask
   // events so far: fault, trigger and refused access; irq follows mask and clear
   task automatic t_irq();
      rdr(P, `FSGI_OFF_IRQ_STATUS);
      chk(rd[2:0], 32'h7);
      chk(irq, 32'h0);
      wr(P, `FSGI_OFF_IRQ_MASK, 32'h2);
      repeat (2) @(posedge core_clk);
      chk(irq, 32'h1);
      wr(P, `FSGI_OFF_IRQ_STATUS, 32'h7);
      repeat (2) @(posedge core_clk);
      chk(irq, 32'h0);
   endtask
   //////////////////////////////////////////////////////////////////////////////
   // clock, reset and main sequence
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      t_fault();
      t_trig();
      t_irq();
      end_of_test();
   end
endmodule
